/* File: logic/dft_pkg.sv */
package dft_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [5:0] DFT_IDX_HDISP = 6'h04;
  localparam logic [5:0] DFT_IDX_HBLANK = 6'h05;
  localparam logic [5:0] DFT_IDX_VDISP_LO = 6'h08;
  localparam logic [5:0] DFT_IDX_VDISP_HI = 6'h09;
  localparam logic [5:0] DFT_IDX_VBLANK = 6'h0A;
  localparam logic [5:0] DFT_IDX_LOFS_LO = 6'h16;
  localparam logic [5:0] DFT_IDX_LOFS_HI = 6'h17;
  localparam logic [5:0] DFT_IDX_HFB_CTL = 6'h1B;
  localparam logic [5:0] DFT_IDX_PERF = 6'h22;
  localparam logic [5:0] DFT_IDX_CTRL = 6'h30;
  localparam logic [5:0] DFT_IDX_STAT = 6'h31;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and widths.
  localparam int DFT_HDISP_W = 7;
  localparam int DFT_HBLANK_W = 5;
  localparam int DFT_VDISP_HI_W = 2;
  localparam int DFT_VBLANK_W = 6;
  localparam int DFT_HFB_DIS_BIT = 0;
  localparam int DFT_CTRL_EN_BIT = 0;
  localparam int DFT_CTRL_MONO_BIT = 1;
  localparam int DFT_CTRL_DIV_LSB = 2;
  localparam int DFT_STAT_ACT_BIT = 15;
  localparam int DFT_STAT_FRM_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed sizes.
  localparam logic [7:0] DFT_REG_RESET = 8'h00;
  localparam logic [7:0] DFT_CTRL_RESET = 8'h00;
  localparam logic [21:0] DFT_MEM_BYTES = 22'h200000;
  localparam logic [10:0] DFT_CNT_ONE = 11'h001;

  typedef logic [10:0] dft_cnt_t;

  // Horizontal period: eight pixel clocks per unit, one more unit than programmed.
  function automatic dft_cnt_t dft_hper(input logic [6:0] field);
    dft_hper = ({4'h0, field} + DFT_CNT_ONE) << 3;
  endfunction

  // Vertical period: one more line than programmed.
  function automatic dft_cnt_t dft_vper(input logic [9:0] field);
    dft_vper = {1'b0, field} + DFT_CNT_ONE;
  endfunction

endpackage

/* File: logic/dft_scan.sv */
module dft_scan
  import dft_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration.
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic [6:0] hd_i,
  input wire logic [4:0] hb_i,
  input wire logic [9:0] vd_i,
  input wire logic [5:0] vb_i,
  // Scan state.
  output dft_pkg::dft_cnt_t h_o,
  output dft_pkg::dft_cnt_t v_o,
  output logic active_o,
  output logic line_end_o,
  output logic frame_end_o
);
  import dft_pkg::*;

  dft_cnt_t h_q, h_d, v_q, v_d, horiz_display_period, vert_display_period, htot, vtot;
  logic act_q, act_d, le_q, le_d, fe_q, fe_d, h_end, v_end;

  ////////////////////////////////////////////////////////////////////////////////
  // vertical display lines.
  assign vert_display_period = dft_vper(vd_i);
  assign vtot = vert_display_period + dft_vper({4'h0, vb_i});
  assign horiz_display_period = dft_hper(hd_i);
  assign htot = horiz_display_period + dft_hper({2'b00, hb_i});
  // Using >= lets a shrunk period recover at once instead of running to overflow.
  assign h_end = h_q >= (htot - DFT_CNT_ONE);
  assign v_end = v_q >= (vtot - DFT_CNT_ONE);

  always_comb begin
    h_d = h_q;
    v_d = v_q;
    le_d = 1'b0;
    fe_d = 1'b0;
    if (!en_i) begin
      h_d = '0;
      v_d = '0;
    end else if (tick_i) begin
      if (h_end) begin
        h_d = '0;
        le_d = 1'b1;
        // frame is total width times total lines.
        if (v_end) begin
          v_d = '0;
          fe_d = 1'b1;
        end else begin
          v_d = v_q + DFT_CNT_ONE;
        end
      end else begin
        h_d = h_q + DFT_CNT_ONE;
      end
    end
    act_d = en_i && (h_d < horiz_display_period) && (v_d < vert_display_period);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      h_q <= '0;
      v_q <= '0;
      act_q <= 1'b0;
      le_q <= 1'b0;
      fe_q <= 1'b0;
    end else begin
      h_q <= h_d;
      v_q <= v_d;
      act_q <= act_d;
      le_q <= le_d;
      fe_q <= fe_d;
    end
  end

  assign h_o = h_q;
  assign v_o = v_q;
  assign active_o = act_q;
  assign line_end_o = le_q;
  assign frame_end_o = fe_q;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_line_wrap;
    en_i && tick_i && h_end;
  endsequence

  sequence s_frame_wrap;
    en_i && tick_i && h_end && v_end;
  endsequence

  a_hcount_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_line_wrap |=> (h_q == 11'h000) && line_end_o)
    else $error("Pixel counter did not wrap at line end.");

  a_vcount_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_line_wrap and !v_end) |=> (v_q == $past(v_q) + 11'h001) && !frame_end_o)
    else $error("Line counter did not advance by one.");

  a_frame_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_frame_wrap |=> frame_end_o && (v_q == 11'h000))
    else $error("Frame end not flagged at last line.");

  a_hcount_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && !tick_i) |=> $stable(h_q) && $stable(v_q) && !line_end_o)
    else $error("Counters moved without a pixel tick.");

  a_active_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && $past(en_i) && $stable(hd_i) && $stable(vd_i)) |->
      (active_o == ((h_q < horiz_display_period) && (v_q < vert_display_period))))
    else $error("Active flag outside display window.");

endmodule

/* File: logic/dft_top.sv */
// Operation
// - Vertical display lines equal one plus ten-bit high/low vertical value.
// - Vertical blank lines equal one plus six-bit blank field.
// - Horizontal display lasts eight pixel clocks times one plus seven-bit field.
// - Horizontal blank lasts eight pixel clocks times one plus five-bit field.
// - Frame lasts total line width times total line count in pixel clocks.
// - Bit zero of half-frame control disables the half-frame buffer.
// - Half-frame buffer sits at the top of physical memory.
module dft_top
  import dft_pkg::*;
#(
  parameter logic [21:0] MEM_BYTES = dft_pkg::DFT_MEM_BYTES
) (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  // Avalon-MM register slave.
  input wire logic [7:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [31:0] WRITEDATA_I,
  input wire logic [3:0] BYTEENABLE_I,
  output logic [31:0] READDATA_O,
  output logic WAITREQUEST_O,
  // Display timing.
  output logic PIXEL_TICK_O,
  output logic DISPLAY_ACTIVE_O,
  output logic LINE_END_O,
  output logic FRAME_END_O,
  output dft_pkg::dft_cnt_t H_COUNT_O,
  output dft_pkg::dft_cnt_t V_COUNT_O,
  // Memory layout and settings for the fetch logic.
  output logic HFB_DISABLE_O,
  output logic [21:0] HFB_BASE_O,
  output logic [15:0] LINE_OFFSET_O,
  output logic [7:0] PERF_CFG_O
);
  import dft_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0] hdisp_q, hdisp_d, hblank_q, hblank_d;
  logic [7:0] vlo_q, vlo_d, vhi_q, vhi_d, vblank_q, vblank_d;
  logic [7:0] lofs_lo_q, lofs_lo_d, lofs_hi_q, lofs_hi_d;
  logic [7:0] hfb_q, hfb_d, perf_q, perf_d, ctrl_q, ctrl_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic req, wr_go;
  logic [5:0] idx;

  // Timing state.
  logic [1:0] div_q, div_d, div_sel;
  logic pix_tick, scan_en, mono;
  logic [7:0] frm_q, frm_d;
  logic [21:0] area, hfb_size, base_q, base_d;
  logic [31:0] status;
  dft_cnt_t h_cnt, v_cnt, hdp_w, vdp_w;
  logic active, line_end, frame_end;

  assign req = READ_I || WRITE_I;
  assign idx = ADDRESS_I[7:2];
  // One wait state: the first cycle of every request is held off, the second answers.
  assign WAITREQUEST_O = req && !ack_q;
  assign wr_go = WRITE_I && ack_q && BYTEENABLE_I[0];
  assign ack_d = req && !ack_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes; only byte lane 0 carries data, upper lanes are ignored.
  always_comb begin
    hdisp_d = hdisp_q;
    hblank_d = hblank_q;
    vlo_d = vlo_q;
    vhi_d = vhi_q;
    vblank_d = vblank_q;
    lofs_lo_d = lofs_lo_q;
    lofs_hi_d = lofs_hi_q;
    hfb_d = hfb_q;
    perf_d = perf_q;
    ctrl_d = ctrl_q;
    if (wr_go) begin
      case (idx)
        DFT_IDX_HDISP: begin
          hdisp_d = WRITEDATA_I[7:0];
        end
        DFT_IDX_HBLANK: begin
          hblank_d = WRITEDATA_I[7:0];
        end
        DFT_IDX_VDISP_LO: begin
          vlo_d = WRITEDATA_I[7:0];
        end
        DFT_IDX_VDISP_HI: begin
          vhi_d = WRITEDATA_I[7:0];
        end
        DFT_IDX_VBLANK: begin
          vblank_d = WRITEDATA_I[7:0];
        end
        DFT_IDX_LOFS_LO: begin
          lofs_lo_d = WRITEDATA_I[7:0];
        end
        DFT_IDX_LOFS_HI: begin
          lofs_hi_d = WRITEDATA_I[7:0];
        end
        DFT_IDX_HFB_CTL: begin
          hfb_d = WRITEDATA_I[7:0];
        end
        DFT_IDX_PERF: begin
          perf_d = WRITEDATA_I[7:0];
        end
        DFT_IDX_CTRL: begin
          ctrl_d = WRITEDATA_I[7:0];
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the held-off cycle so it stands when waitrequest drops.
  assign status = {8'h00, frm_q, active, 4'h0, v_cnt};

  always_comb begin
    rdata_d = rdata_q;
    if (READ_I && !ack_q) begin
      case (idx)
        DFT_IDX_HDISP: begin
          rdata_d = {24'h0, hdisp_q};
        end
        DFT_IDX_HBLANK: begin
          rdata_d = {24'h0, hblank_q};
        end
        DFT_IDX_VDISP_LO: begin
          rdata_d = {24'h0, vlo_q};
        end
        DFT_IDX_VDISP_HI: begin
          rdata_d = {24'h0, vhi_q};
        end
        DFT_IDX_VBLANK: begin
          rdata_d = {24'h0, vblank_q};
        end
        DFT_IDX_LOFS_LO: begin
          rdata_d = {24'h0, lofs_lo_q};
        end
        DFT_IDX_LOFS_HI: begin
          rdata_d = {24'h0, lofs_hi_q};
        end
        DFT_IDX_HFB_CTL: begin
          rdata_d = {24'h0, hfb_q};
        end
        DFT_IDX_PERF: begin
          rdata_d = {24'h0, perf_q};
        end
        DFT_IDX_CTRL: begin
          rdata_d = {24'h0, ctrl_q};
        end
        DFT_IDX_STAT: begin
          rdata_d = status;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel clock derived from the core clock, divided by one to four.
  assign div_sel = ctrl_q[DFT_CTRL_DIV_LSB +: 2];
  assign scan_en = ctrl_q[DFT_CTRL_EN_BIT];
  assign mono = ctrl_q[DFT_CTRL_MONO_BIT];
  assign pix_tick = scan_en && (div_q >= div_sel);

  always_comb begin
    div_d = div_q;
    frm_d = frm_q;
    if (!scan_en || pix_tick) begin
      div_d = 2'h0;
    end else begin
      div_d = div_q + 2'h1;
    end
    if (frame_end) begin
      frm_d = frm_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The area product is recomputed every cycle; a long path, but the core clock is slow.
  assign hdp_w = dft_hper(hdisp_q[DFT_HDISP_W-1:0]);
  assign vdp_w = dft_vper({vhi_q[DFT_VDISP_HI_W-1:0], vlo_q});
  assign area = {11'h000, hdp_w} * {11'h000, vdp_w};

  // half-frame buffer off when bit set.
  always_comb begin
    if (hfb_q[DFT_HFB_DIS_BIT]) begin
      hfb_size = 22'h000000;
    end else if (mono) begin
      hfb_size = area >> 4;
    end else begin
      hfb_size = area >> 2;
    end
    base_d = MEM_BYTES - hfb_size;
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hdisp_q <= DFT_REG_RESET;
      hblank_q <= DFT_REG_RESET;
      vlo_q <= DFT_REG_RESET;
      vhi_q <= DFT_REG_RESET;
      vblank_q <= DFT_REG_RESET;
      lofs_lo_q <= DFT_REG_RESET;
      lofs_hi_q <= DFT_REG_RESET;
      hfb_q <= DFT_REG_RESET;
      perf_q <= DFT_REG_RESET;
      ctrl_q <= DFT_CTRL_RESET;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      div_q <= 2'h0;
      frm_q <= 8'h00;
      base_q <= MEM_BYTES;
    end else begin
      hdisp_q <= hdisp_d;
      hblank_q <= hblank_d;
      vlo_q <= vlo_d;
      vhi_q <= vhi_d;
      vblank_q <= vblank_d;
      lofs_lo_q <= lofs_lo_d;
      lofs_hi_q <= lofs_hi_d;
      hfb_q <= hfb_d;
      perf_q <= perf_d;
      ctrl_q <= ctrl_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      div_q <= div_d;
      frm_q <= frm_d;
      base_q <= base_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  dft_scan u_scan (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESET_N_I),
    .en_i(scan_en),
    .tick_i(pix_tick),
    .hd_i(hdisp_q[DFT_HDISP_W-1:0]),
    .hb_i(hblank_q[DFT_HBLANK_W-1:0]),
    .vd_i({vhi_q[DFT_VDISP_HI_W-1:0], vlo_q}),
    .vb_i(vblank_q[DFT_VBLANK_W-1:0]),
    .h_o(h_cnt),
    .v_o(v_cnt),
    .active_o(active),
    .line_end_o(line_end),
    .frame_end_o(frame_end)
  );

  assign READDATA_O = rdata_q;
  assign PIXEL_TICK_O = pix_tick;
  assign DISPLAY_ACTIVE_O = active;
  assign LINE_END_O = line_end;
  assign FRAME_END_O = frame_end;
  assign H_COUNT_O = h_cnt;
  assign V_COUNT_O = v_cnt;
  assign HFB_DISABLE_O = hfb_q[DFT_HFB_DIS_BIT];
  assign HFB_BASE_O = base_q;
  assign LINE_OFFSET_O = {lofs_hi_q, lofs_lo_q};
  assign PERF_CFG_O = perf_q;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_req_held;
    req && WAITREQUEST_O;
  endsequence

  a_wait_one: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    s_req_held |=> !WAITREQUEST_O)
    else $error("Request held off for more than one cycle.");

  a_write_lands: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    (WRITE_I && !WAITREQUEST_O && BYTEENABLE_I[0] && idx == DFT_IDX_HDISP) |=>
      (hdisp_q == $past(WRITEDATA_I[7:0])))
    else $error("Display width write not stored.");

  a_tick_div2: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    (pix_tick && div_sel == 2'h1) ##1 (scan_en && div_sel == 2'h1) ##1
      (scan_en && div_sel == 2'h1) |-> pix_tick && !$past(pix_tick))
    else $error("Pixel tick spacing wrong at divide by two.");

  a_hfb_top: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    !hfb_q[DFT_HFB_DIS_BIT] |=> (HFB_BASE_O + $past(hfb_size) == MEM_BYTES))
    else $error("Half-frame buffer not at top of memory.");

  a_hfb_off: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    (hfb_q[DFT_HFB_DIS_BIT] && $past(hfb_q[DFT_HFB_DIS_BIT])) |-> HFB_BASE_O == MEM_BYTES)
    else $error("Disabled half-frame buffer still reserves memory.");

endmodule

/* File: test/dft_panel_model.sv */
module dft_panel_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Timing seen at the panel.
  input wire logic active_i,
  input wire logic line_end_i,
  input wire logic frame_end_i,
  // Last frame as measured.
  output logic [31:0] cyc_o,
  output logic [31:0] act_o,
  output logic [31:0] lines_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cyc_q;
  logic [31:0] act_q;
  logic [31:0] lines_q;

  ////////////////////////////////////////////////////////////////////////////////
  // frame size measurement.
  // The panel only listens; its count for the first frame after enable includes the cycles before enable, so it is not judged.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_q <= 32'h0;
      act_q <= 32'h0;
      lines_q <= 32'h0;
      cyc_o <= 32'h0;
      act_o <= 32'h0;
      lines_o <= 32'h0;
      done_o <= 1'b0;
    end else if (frame_end_i) begin
      cyc_o <= cyc_q + 32'h1;
      act_o <= act_q + 32'(active_i);
      lines_o <= lines_q + 32'(line_end_i);
      cyc_q <= 32'h0;
      act_q <= 32'h0;
      lines_q <= 32'h0;
      done_o <= 1'b1;
    end else begin
      cyc_q <= cyc_q + 32'h1;
      act_q <= act_q + 32'(active_i);
      lines_q <= lines_q + 32'(line_end_i);
      done_o <= 1'b0;
    end
  end
endmodule

/* File: test/tb_dft_top.sv */
module tb_dft_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dft_pkg::*;
  localparam logic [21:0] MEM = 22'h200000;
  localparam logic [5:0] IDX [10] = '{DFT_IDX_HDISP, DFT_IDX_HBLANK, DFT_IDX_VDISP_LO,
    DFT_IDX_VDISP_HI, DFT_IDX_VBLANK, DFT_IDX_LOFS_LO, DFT_IDX_LOFS_HI, DFT_IDX_HFB_CTL,
    DFT_IDX_PERF, DFT_IDX_CTRL};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic waitreq, tick, active, lend, fend, hfb_dis;
  dft_cnt_t hcnt, vcnt;
  logic [21:0] hfb_base;
  logic [15:0] lofs;
  logic [7:0] perf;
  logic [31:0] m_cyc, m_act, m_lines;
  logic m_done;
  logic [31:0] rd_q[$];
  logic [95:0] fr_q[$];
  logic [95:0] fe;
  logic [7:0] regv [10];
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  dft_top #(.MEM_BYTES(MEM)) DUT (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .ADDRESS_I(addr),
    .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wdata), .BYTEENABLE_I(be), .READDATA_O(rdata),
    .WAITREQUEST_O(waitreq), .PIXEL_TICK_O(tick), .DISPLAY_ACTIVE_O(active),
    .LINE_END_O(lend), .FRAME_END_O(fend), .H_COUNT_O(hcnt), .V_COUNT_O(vcnt),
    .HFB_DISABLE_O(hfb_dis), .HFB_BASE_O(hfb_base), .LINE_OFFSET_O(lofs), .PERF_CFG_O(perf));

  dft_panel_model u_panel (.clk_i(clk), .rst_n_i(rst_n), .active_i(active),
    .line_end_i(lend), .frame_end_i(fend), .cyc_o(m_cyc), .act_o(m_act),
    .lines_o(m_lines), .done_o(m_done));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_read(input logic [31:0] exp, input logic [31:0] got);
    cmp("readdata", exp, got);
  endtask

  task automatic cmp_frame(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp(what, exp, got);
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Requests are held until the edge that sees waitrequest low; byte lanes above 0 are noise.
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic b0);
    addr <= {idx, 2'($urandom)};
    rd <= !w;
    wr <= w;
    wdata <= {24'($urandom), d};
    be <= {3'($urandom), b0};
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
  endtask

  task automatic rd_reg(input logic [5:0] idx, input logic [7:0] exp);
    rd_q.push_back({24'h0, exp});
    bus(1'b0, idx, 8'h00, 1'b1);
  endtask

  task automatic idle();
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_fend();
    do begin
      @(posedge clk);
    end while (fend !== 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Results are compared in arrival order against the notes left by the driver.
  // Read data is taken at the same rising edge that sees waitrequest low.
  always @(posedge clk) begin
    if (rd && waitreq === 1'b0 && rd_q.size() > 0) begin
      cmp_read(rd_q.pop_front(), rdata);
    end
    if (m_done === 1'b1 && fr_q.size() > 0) begin
      fe = fr_q.pop_front();
      cmp_frame("frame_cycles", fe[95:64], m_cyc);
      cmp_frame("active_cycles", fe[63:32], m_act);
      cmp_frame("frame_lines", fe[31:0], m_lines);
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int s, hd, hb, vd, vb, dv, px, ln;
    s = $urandom(32'h2823);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // All registers come up cleared.
    foreach (IDX[i]) rd_reg(IDX[i], 8'h00);
    // Back-to-back random writes, then read back; control stays off.
    foreach (IDX[i]) begin
      regv[i] = (i == 9) ? 8'h00 : 8'($urandom);
      bus(1'b1, IDX[i], regv[i], 1'b1);
    end
    foreach (IDX[i]) rd_reg(IDX[i], regv[i]);
    bus(1'b1, 6'h3F, 8'hA5, 1'b1);
    rd_reg(6'h3F, 8'h00);
    bus(1'b1, DFT_IDX_PERF, ~regv[8], 1'b0);
    rd_reg(DFT_IDX_PERF, regv[8]);
    idle();
    @(posedge clk);
    cmp("line_offset", {16'h0, regv[6], regv[5]}, {16'h0, lofs});
    cmp("perf_cfg", {24'h0, regv[8]}, {24'h0, perf});
    cmp("hfb_disable", {31'h0, regv[7][0]}, {31'h0, hfb_dis});
    // Half-frame buffer placement, colour then mono, then disabled.
    for (int m = 0; m < 3; m++) begin
      hd = $urandom % 128;
      vd = $urandom % 1024;
      bus(1'b1, DFT_IDX_HDISP, 8'(hd), 1'b1);
      bus(1'b1, DFT_IDX_VDISP_LO, 8'(vd), 1'b1);
      bus(1'b1, DFT_IDX_VDISP_HI, {6'($urandom), 2'(vd >> 8)}, 1'b1);
      bus(1'b1, DFT_IDX_HFB_CTL, {7'($urandom), 1'(m == 2)}, 1'b1);
      bus(1'b1, DFT_IDX_CTRL, {6'h0, 1'(m == 1), 1'b0}, 1'b1);
      idle();
      repeat (2) @(posedge clk);
      px = (m == 2) ? 0 : (hd + 1) * 8 * (vd + 1) / ((m == 1) ? 16 : 4);
      cmp("hfb_base", 32'(MEM) - 32'(px), {10'h0, hfb_base});
    end
    // Frames with every pixel divide, the last one using the high line bits.
    for (int k = 0; k < 5; k++) begin
      hd = $urandom % 4;
      hb = $urandom % 4;
      vd = (k == 4) ? 256 : $urandom % 4;
      vb = $urandom % 4;
      dv = k % 4;
      bus(1'b1, DFT_IDX_HDISP, {1'($urandom), 7'(hd)}, 1'b1);
      bus(1'b1, DFT_IDX_HBLANK, {3'($urandom), 5'(hb)}, 1'b1);
      bus(1'b1, DFT_IDX_VDISP_LO, 8'(vd), 1'b1);
      bus(1'b1, DFT_IDX_VDISP_HI, {6'($urandom), 2'(vd >> 8)}, 1'b1);
      bus(1'b1, DFT_IDX_VBLANK, {2'($urandom), 6'(vb)}, 1'b1);
      bus(1'b1, DFT_IDX_CTRL, {4'h0, 2'(dv), 2'b01}, 1'b1);
      idle();
      wait_fend();
      repeat (2) @(posedge clk);
      px = (hd + 1) * 8 + (hb + 1) * 8;
      ln = vd + 1 + vb + 1;
      fr_q.push_back({32'(px * ln * (dv + 1)), 32'((hd + 1) * 8 * (vd + 1) * (dv + 1)),
        32'(ln)});
      wait_fend();
      repeat (3) @(posedge clk);
      bus(1'b1, DFT_IDX_CTRL, 8'h00, 1'b1);
      idle();
      repeat (2) @(posedge clk);
      cmp("h_count", 32'h0, {21'h0, hcnt});
      cmp("v_count", 32'h0, {21'h0, vcnt});
      cmp("pixel_tick", 32'h0, {31'h0, tick});
      cmp("active", 32'h0, {31'h0, active});
      rd_q.push_back({8'h00, 8'(2 * (k + 1)), 16'h0000});
      bus(1'b0, DFT_IDX_STAT, 8'h00, 1'b1);
    end
    idle();
    @(posedge clk);
    cmp("pending_notes", 32'h0, 32'(rd_q.size() + fr_q.size()));
    complete_run();
  end
endmodule
